// ---- logic/fsp_pkg.sv ----
// Constants and types shared by the status protection configuration block.
package fsp_pkg;
    localparam int ADDR_W = 21;
    localparam int UNITS  = 32;

    // Select codes for the three status bytes.
    localparam logic [1:0] SEL_SR1 = 2'h1;
    localparam logic [1:0] SEL_SR2 = 2'h2;
    localparam logic [1:0] SEL_SR3 = 2'h3;

    // Status byte one field positions.
    localparam int P_SRP   = 7;
    localparam int P_SEC   = 6;
    localparam int P_TB    = 5;
    localparam int P_BP_HI = 4;
    localparam int P_BP_LO = 2;
    localparam int P_WEL   = 1;
    localparam int P_BUSY  = 0;

    // Status byte two field positions.
    localparam int P_SUS   = 7;
    localparam int P_CMP   = 6;
    localparam int P_LB_HI = 5;
    localparam int P_LB_LO = 3;
    localparam int P_RSV   = 2;
    localparam int P_QE    = 1;
    localparam int P_SRL   = 0;

    // Status byte three field positions.
    localparam int P_HRST   = 7;
    localparam int P_DRV_HI = 6;
    localparam int P_DRV_LO = 5;
    localparam int P_WPS    = 2;

    // Reset values.
    localparam logic [1:0]       RST_DRV  = 2'h3;
    localparam logic [2:0]       RST_LB   = 3'h0;
    localparam logic [2:0]       RST_BP   = 3'h0;
    localparam logic [UNITS-1:0] RST_UNIT = 32'hffffffff;
    localparam logic [1:0]       RST_PIN  = 2'h3;

    // Array geometry.
    localparam logic [21:0] BLK_SIZE   = 22'h010000;
    localparam logic [21:0] SEC_SIZE   = 22'h001000;
    localparam logic [21:0] ARRAY_SIZE = 22'h200000;

    typedef struct packed {
        logic       srp;
        logic       sec;
        logic       tb;
        logic [2:0] bp;
        logic       cmp;
        logic [2:0] lb;
        logic       qe;
        logic       status_lock;
        logic       protect_scheme_select;
        logic [1:0] drv;
        logic       hold_rst;
    } fsp_cfg_t;

    typedef struct packed {
        logic              none;
        logic [ADDR_W-1:0] lo;
        logic [ADDR_W-1:0] hi;
    } fsp_range_t;
endpackage

// ---- logic/fsp_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for the two control pins.
`timescale 1ns/1ps
module fsp_pin_sync
    import fsp_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       en_i,
    // Raw pins and filtered levels.
    input  wire logic [1:0] pin_i,
    output logic      [1:0] lvl_o
);
    logic [1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [1:0] lvl_next;

    // A level counts only when stages two and three agree.
    always_comb begin
        lvl_next = lvl_reg;
        for (int i = 0; i < 2; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                lvl_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_reg  <= RST_PIN;
            s2_reg  <= RST_PIN;
            s3_reg  <= RST_PIN;
            lvl_reg <= RST_PIN;
        end else if (en_i) begin
            s1_reg  <= pin_i;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign lvl_o = lvl_reg;
endmodule

// ---- logic/fsp_prot_range.sv ----
// Decodes the range fields into a protected address window, complement off.
`timescale 1ns/1ps
module fsp_prot_range
    import fsp_pkg::*;
(
    // Stored protection fields.
    input  wire logic       sec_i,
    input  wire logic       tb_i,
    input  wire logic [2:0] bp_i,
    // Decoded window.
    output fsp_range_t      rng_o
);
    logic [21:0] size;
    logic [2:0]  steps;

    always_comb begin
        steps = bp_i - 3'h1;
        // Small units stop growing at 32KB.
        if (sec_i && bp_i[2]) begin
            steps = 3'h3;
        end
        size = (sec_i ? SEC_SIZE : BLK_SIZE) << steps;
        if (bp_i[2:1] == 2'h3) begin
            size = ARRAY_SIZE;
        end
        rng_o.none = (bp_i == RST_BP);
        if (tb_i && bp_i[2:1] != 2'h3) begin
            rng_o.lo = '0;
            rng_o.hi = ADDR_W'(size - 22'h1);
        end else begin
            rng_o.lo = ADDR_W'(ARRAY_SIZE - size);
            rng_o.hi = '1;
        end
    end
endmodule

// ---- logic/fsp_status_ctrl.sv ----
// Status byte storage, pin function control and program/erase protection check.
// How it works
// - Three one-time lock bits at positions 13..11, zero from reset.
// - Lock bits only set; a set bit rejects its security area until the next reset.
// - Quad enable at position 9, default 0, leaves protect and pause pins active.
// - Quad enable 1 makes both pins data lines, their functions off.
// - Byte two: suspend, complement, three locks, reserved, quad enable, status lock.
// - Scheme select 0 uses complement, unit size, top/bottom and range fields.
// - Scheme select 1 uses the per-block lock array instead.
// - Reset sets every per-block lock bit to one.
// - Drive field 00 full, 01 three quarters, 10 half, 11 quarter; default 11.
// - Pin select 0 makes shared pin pause; 1 makes it active-low reset.
// - Shared pin functions only with quad enable 0; otherwise data only.
// - Reserved bits read zero here and writes to them are ignored.
// - Range 000 protects nothing, 11x everything, others 1/32 to 1/2 in blocks, 4KB to 32KB in sectors.
// - Top/bottom 0 anchors at top; unit select 1 means 4KB sectors.
// - Complement 1 inverts the computed protection.
// - Program or erase touching any protected byte is refused.
`timescale 1ns/1ps
module fsp_status_ctrl
    import fsp_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic              en_i,
    // Status write from the instruction decoder.
    input  wire logic              wr_i,
    input  wire logic [1:0]        wr_sel_i,
    input  wire logic [7:0]        wr_data_i,
    input  wire logic              write_latch_i,
    input  wire logic              busy_i,
    input  wire logic              paused_i,
    output logic                   wr_done_o,
    output logic                   wr_refused_o,
    // Status read.
    input  wire logic [1:0]        rd_sel_i,
    output logic      [7:0]        rd_data_o,
    // Shared pins and their functions.
    input  wire logic              wp_n_pin_i,
    input  wire logic              hold_n_pin_i,
    output logic                   quad_data_en_o,
    output logic                   pause_o,
    output logic                   pin_reset_o,
    output logic      [1:0]        drive_strength_o,
    // Per-block lock array writes.
    input  wire logic              ul_wr_i,
    input  wire logic [4:0]        ul_idx_i,
    input  wire logic              ul_val_i,
    // Program and erase check.
    input  wire logic              pe_req_i,
    input  wire logic [ADDR_W-1:0] pe_start_i,
    input  wire logic [ADDR_W-1:0] pe_end_i,
    input  wire logic              pe_sec_area_i,
    input  wire logic [1:0]        pe_area_idx_i,
    output logic                   pe_ok_o,
    output logic                   pe_block_o
);
    ////////////////////////////////////////////////////////////////////////////
    fsp_cfg_t         cfg_reg, cfg_next;
    logic [UNITS-1:0] unit_lock_reg, unit_lock_next;
    logic [7:0]       rd_data_reg, rd_data_next;
    logic             wr_done_reg, wr_done_next;
    logic             wr_ref_reg, wr_ref_next;
    logic             pe_ok_reg, pe_ok_next;
    logic             pe_blk_reg, pe_blk_next;
    logic [1:0]       pin_lvl;
    logic             wp_n_s, hold_n_s;
    logic             sr_locked, wr_ok;
    fsp_range_t       rng;
    logic             range_hit, unit_hit, blk;
    logic [UNITS-1:0] unit_hit_v;

    fsp_pin_sync u_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .en_i   (en_i),
        .pin_i  ({hold_n_pin_i, wp_n_pin_i}),
        .lvl_o  (pin_lvl)
    );

    assign wp_n_s   = pin_lvl[0];
    assign hold_n_s = pin_lvl[1];

    fsp_prot_range u_range (
        .sec_i (cfg_reg.sec),
        .tb_i  (cfg_reg.tb),
        .bp_i  (cfg_reg.bp),
        .rng_o (rng)
    );

    ////////////////////////////////////////////////////////////////////////////
    // The protect pin only gates writes while quad mode is off.
    assign sr_locked = cfg_reg.status_lock | (cfg_reg.srp & ~cfg_reg.qe & ~wp_n_s);
    assign wr_ok     = wr_i & write_latch_i & ~busy_i & ~sr_locked;

    always_comb begin
        cfg_next     = cfg_reg;
        wr_done_next = wr_ok;
        wr_ref_next  = wr_i & ~wr_ok;
        if (wr_ok) begin
            if (wr_sel_i == SEL_SR1) begin
                cfg_next.srp = wr_data_i[P_SRP];
                cfg_next.sec = wr_data_i[P_SEC];
                cfg_next.tb  = wr_data_i[P_TB];
                cfg_next.bp  = wr_data_i[P_BP_HI:P_BP_LO];
            end else if (wr_sel_i == SEL_SR2) begin
                cfg_next.cmp = wr_data_i[P_CMP];
                cfg_next.lb  = cfg_reg.lb | wr_data_i[P_LB_HI:P_LB_LO];
                cfg_next.qe  = wr_data_i[P_QE];
                cfg_next.status_lock = wr_data_i[P_SRL];
            end else if (wr_sel_i == SEL_SR3) begin
                cfg_next.hold_rst = wr_data_i[P_HRST];
                cfg_next.drv      = wr_data_i[P_DRV_HI:P_DRV_LO];
                cfg_next.protect_scheme_select      = wr_data_i[P_WPS];
            end
        end
    end

    // Non-volatile bits come back at their factory values on every reset.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_reg     <= '0;
            cfg_reg.lb  <= RST_LB;
            cfg_reg.bp  <= RST_BP;
            cfg_reg.drv <= RST_DRV;
            wr_done_reg <= 1'b0;
            wr_ref_reg  <= 1'b0;
        end else if (en_i) begin
            cfg_reg     <= cfg_next;
            wr_done_reg <= wr_done_next;
            wr_ref_reg  <= wr_ref_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reserved and unmapped positions read as zero.
    always_comb begin
        rd_data_next = 8'h00;
        if (rd_sel_i == SEL_SR1) begin
            rd_data_next[P_SRP]           = cfg_reg.srp;
            rd_data_next[P_SEC]           = cfg_reg.sec;
            rd_data_next[P_TB]            = cfg_reg.tb;
            rd_data_next[P_BP_HI:P_BP_LO] = cfg_reg.bp;
            rd_data_next[P_WEL]           = write_latch_i;
            rd_data_next[P_BUSY]          = busy_i;
        end else if (rd_sel_i == SEL_SR2) begin
            rd_data_next[P_SUS]           = paused_i;
            rd_data_next[P_CMP]           = cfg_reg.cmp;
            rd_data_next[P_LB_HI:P_LB_LO] = cfg_reg.lb;
            rd_data_next[P_QE]            = cfg_reg.qe;
            rd_data_next[P_SRL]           = cfg_reg.status_lock;
        end else if (rd_sel_i == SEL_SR3) begin
            rd_data_next[P_HRST]            = cfg_reg.hold_rst;
            rd_data_next[P_DRV_HI:P_DRV_LO] = cfg_reg.drv;
            rd_data_next[P_WPS]             = cfg_reg.protect_scheme_select;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_reg <= 8'h00;
        end else if (en_i) begin
            rd_data_reg <= rd_data_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        unit_lock_next = unit_lock_reg;
        if (ul_wr_i) begin
            unit_lock_next[ul_idx_i] = ul_val_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            unit_lock_reg <= RST_UNIT;
        end else if (en_i) begin
            unit_lock_reg <= unit_lock_next;
        end
    end

    // Block-level granularity only; a locked block refuses any overlap.
    for (genvar i = 0; i < UNITS; i++) begin : g_unit
        assign unit_hit_v[i] = unit_lock_reg[i] &
                               (5'(i) >= pe_start_i[ADDR_W-1:16]) &
                               (5'(i) <= pe_end_i[ADDR_W-1:16]);
    end

    assign unit_hit = |unit_hit_v;

    // Window from the live fields, so a completed write steers the next command.
    always_comb begin
        if (cfg_reg.cmp) begin
            range_hit = rng.none | (pe_start_i < rng.lo) | (pe_end_i > rng.hi);
        end else begin
            range_hit = ~rng.none & (pe_start_i <= rng.hi) & (pe_end_i >= rng.lo);
        end
        if (pe_sec_area_i) begin
            blk = (pe_area_idx_i == 2'h0) | cfg_reg.lb[pe_area_idx_i - 2'h1];
        end else begin
            blk = cfg_reg.protect_scheme_select ? unit_hit : range_hit;
        end
        pe_ok_next  = pe_req_i & ~blk;
        pe_blk_next = pe_req_i & blk;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pe_ok_reg  <= 1'b0;
            pe_blk_reg <= 1'b0;
        end else if (en_i) begin
            pe_ok_reg  <= pe_ok_next;
            pe_blk_reg <= pe_blk_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign wr_done_o        = wr_done_reg;
    assign wr_refused_o     = wr_ref_reg;
    assign rd_data_o        = rd_data_reg;
    assign pe_ok_o          = pe_ok_reg;
    assign pe_block_o       = pe_blk_reg;
    assign drive_strength_o = cfg_reg.drv;
    assign quad_data_en_o   = cfg_reg.qe;
    assign pause_o          = ~cfg_reg.qe & ~cfg_reg.hold_rst & ~hold_n_s;
    assign pin_reset_o      = ~cfg_reg.qe & cfg_reg.hold_rst & ~hold_n_s;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_wr2;
        en_i && wr_ok && wr_sel_i == SEL_SR2;
    endsequence

    sequence s_arr_req;
        en_i && pe_req_i && !pe_sec_area_i;
    endsequence

    chk_otp_sticky: assert property (
        en_i |=> ((cfg_reg.lb & $past(cfg_reg.lb)) == $past(cfg_reg.lb)))
        else $error("Security lock bit cleared.");
    chk_otp_reject: assert property (
        en_i && pe_req_i && pe_sec_area_i && pe_area_idx_i != 2'h0
        && cfg_reg.lb[pe_area_idx_i - 2'h1] |=> pe_block_o && !pe_ok_o)
        else $error("Locked security area not refused.");
    chk_qe_pins: assert property (
        cfg_reg.qe |-> quad_data_en_o && !pause_o && !pin_reset_o)
        else $error("Pin function active in quad mode.");
    chk_wr_lands: assert property (
        s_wr2 |=> cfg_reg.qe == $past(wr_data_i[P_QE]) && wr_done_o)
        else $error("Quad enable write lost.");
    chk_locked_write: assert property (
        en_i && wr_i && (!write_latch_i || cfg_reg.status_lock)
        |=> $stable(cfg_reg) && wr_refused_o)
        else $error("Status write taken without permission.");
    chk_rsv_zero: assert property (
        en_i && rd_sel_i == SEL_SR2 |=> rd_data_o[P_RSV] == 1'b0)
        else $error("Reserved bit read non-zero.");
    chk_all_prot: assert property (
        s_arr_req and (!cfg_reg.protect_scheme_select && !cfg_reg.cmp && cfg_reg.bp[2:1] == 2'h3)
        |=> pe_block_o)
        else $error("Fully protected array accepted a write.");
    chk_none_prot: assert property (
        s_arr_req and (!cfg_reg.protect_scheme_select && !cfg_reg.cmp && cfg_reg.bp == 3'h0)
        |=> pe_ok_o)
        else $error("Unprotected array refused a write.");
    chk_cmp_inv: assert property (
        s_arr_req and (!cfg_reg.protect_scheme_select && cfg_reg.cmp && cfg_reg.bp == 3'h0)
        |=> pe_block_o)
        else $error("Complement did not protect the array.");
    chk_wps_unit: assert property (
        s_arr_req and (cfg_reg.protect_scheme_select && unit_lock_reg[pe_start_i[ADDR_W-1:16]])
        |=> pe_block_o)
        else $error("Locked block accepted a write.");
endmodule

// ---- verif/fsp_host_model.sv ----
// Host model that issues status byte writes into the block.
`timescale 1ns/1ps
module fsp_host_model
    import fsp_pkg::*;
(
    // Clock.
    input  wire logic       clk_i,
    // Write request toward the block.
    output logic            wr_o,
    output logic      [1:0] sel_o,
    output logic      [7:0] data_o,
    output logic            latch_o,
    // Write answer.
    input  wire logic       done_i,
    input  wire logic       refused_i
);
    initial begin
        wr_o = 1'b0;
        sel_o = 2'h0;
        data_o = 8'h00;
        latch_o = 1'b0;
    end

    // The latch is left low only when a test wants the write refused.
    // Data is inverted after release so a late sample never sees the old byte.
    task automatic write_byte(input logic [1:0] sel, input logic [7:0] d,
                              input logic lat, output logic ok);
        @(posedge clk_i);
        wr_o <= 1'b1;
        sel_o <= sel;
        data_o <= d;
        latch_o <= lat;
        @(posedge clk_i);
        wr_o <= 1'b0;
        sel_o <= 2'h0;
        data_o <= ~d;
        latch_o <= 1'b0;
        @(negedge clk_i);
        ok = done_i && !refused_i;
    endtask
endmodule

// ---- verif/fsp_status_ctrl_bench.sv ----
// Self-checking bench for the status protection configuration block.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module fsp_status_ctrl_bench
    import fsp_pkg::*;
;
    logic              clk_i = 1'b0;
    logic              rstn_i = 1'b0;
    logic              wr_i, write_latch_i, wr_done_o, wr_refused_o, paused_i = 1'b0;
    logic [1:0]        wr_sel_i, rd_sel_i = 2'h0, drive_strength_o;
    logic [7:0]        wr_data_i, rd_data_o;
    logic              hold_n_pin_i = 1'b1, quad_data_en_o, pause_o, pin_reset_o;
    logic              ul_wr_i = 1'b0, ul_val_i = 1'b0, pe_req_i = 1'b0, pe_sec_area_i = 1'b0;
    logic [4:0]        ul_idx_i = 5'h00;
    logic [ADDR_W-1:0] pe_start_i = '0, pe_end_i = '0;
    logic [1:0]        pe_area_idx_i = 2'h0;
    logic              pe_ok_o, pe_block_o;
    int                num_errors = 0, n_compared = 0, cyc = 0;
    // Range cases: {sec, tb, bp}, two probe addresses, expected block for each.
    logic [4:0]        cf [6] = '{5'h00, 5'h01, 5'h0d, 5'h06, 5'h14, 5'h19};
    logic [20:0]       ad [12] = '{21'h1fffff, 21'h000000, 21'h1f0000, 21'h1effff,
                                   21'h0fffff, 21'h100000, 21'h000000, 21'h1fffff,
                                   21'h1f8000, 21'h1f7fff, 21'h000fff, 21'h001000};
    logic              ex [12] = '{0, 0, 1, 0, 1, 0, 1, 1, 1, 0, 1, 0};

    always #4 clk_i = ~clk_i;

    fsp_host_model u_fsp_host_model (
        .clk_i     (clk_i),
        .wr_o      (wr_i),
        .sel_o     (wr_sel_i),
        .data_o    (wr_data_i),
        .latch_o   (write_latch_i),
        .done_i    (wr_done_o),
        .refused_i (wr_refused_o)
    );

    fsp_status_ctrl u_fsp_status_ctrl (
        .clk_i            (clk_i),
        .rstn_i           (rstn_i),
        .en_i             (1'b1),
        .wr_i             (wr_i),
        .wr_sel_i         (wr_sel_i),
        .wr_data_i        (wr_data_i),
        .write_latch_i    (write_latch_i),
        .busy_i           (1'b0),
        .paused_i         (paused_i),
        .wr_done_o        (wr_done_o),
        .wr_refused_o     (wr_refused_o),
        .rd_sel_i         (rd_sel_i),
        .rd_data_o        (rd_data_o),
        .wp_n_pin_i       (1'b1),
        .hold_n_pin_i     (hold_n_pin_i),
        .quad_data_en_o   (quad_data_en_o),
        .pause_o          (pause_o),
        .pin_reset_o      (pin_reset_o),
        .drive_strength_o (drive_strength_o),
        .ul_wr_i          (ul_wr_i),
        .ul_idx_i         (ul_idx_i),
        .ul_val_i         (ul_val_i),
        .pe_req_i         (pe_req_i),
        .pe_start_i       (pe_start_i),
        .pe_end_i         (pe_end_i),
        .pe_sec_area_i    (pe_sec_area_i),
        .pe_area_idx_i    (pe_area_idx_i),
        .pe_ok_o          (pe_ok_o),
        .pe_block_o       (pe_block_o)
    );

    ////////////////////////////////////////////////////////////////////////////////

    task automatic wr(input logic [1:0] s, input logic [7:0] d, input logic lat, input logic e);
        logic ok;
        u_fsp_host_model.write_byte(s, d, lat, ok);
        `CHK(ok, e)
    endtask

    task automatic rd(input logic [1:0] s, input logic [7:0] e);
        @(posedge clk_i);
        rd_sel_i <= s;
        @(posedge clk_i);
        @(negedge clk_i);
        `CHK(rd_data_o, e)
    endtask

    task automatic pe(input logic sa, input logic [1:0] ix, input logic [20:0] s,
                      input logic [20:0] e, input logic blk);
        @(posedge clk_i);
        pe_req_i <= 1'b1;
        pe_sec_area_i <= sa;
        pe_area_idx_i <= ix;
        pe_start_i <= s;
        pe_end_i <= e;
        @(posedge clk_i);
        pe_req_i <= 1'b0;
        @(negedge clk_i);
        `CHK({pe_ok_o, pe_block_o}, {~blk, blk})
    endtask

    // Pin changes pass a three-stage filter, so allow a few edges to settle.
    task automatic pins(input logic p, input logic r, input logic q);
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        `CHK({pause_o, pin_reset_o, quad_data_en_o}, {p, r, q})
    endtask

    task automatic tally_and_finish();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(SEL_SR2, 8'h00);
        rd(SEL_SR3, 8'h60);
        `CHK({drive_strength_o, quad_data_en_o}, 3'h6)
        paused_i <= 1'b1;
        rd(SEL_SR2, 8'h80);
        paused_i <= 1'b0;
        wr(SEL_SR2, 8'h2c, 1'b0, 1'b0);
        rd(SEL_SR2, 8'h00);
        wr(SEL_SR2, 8'h2c, 1'b1, 1'b1);
        rd(SEL_SR2, 8'h28);
        wr(SEL_SR2, 8'h00, 1'b1, 1'b1);
        rd(SEL_SR2, 8'h28);
        pe(1'b1, 2'h1, 21'h0, 21'h0, 1'b1);
        pe(1'b1, 2'h2, 21'h0, 21'h0, 1'b0);
        pe(1'b1, 2'h3, 21'h0, 21'h0, 1'b1);
        for (int d = 0; d < 4; d++) begin
            wr(SEL_SR3, {1'b0, 2'(d), 5'h00}, 1'b1, 1'b1);
            `CHK(drive_strength_o, 2'(d))
        end
        hold_n_pin_i <= 1'b0;
        pins(1'b1, 1'b0, 1'b0);
        wr(SEL_SR3, 8'he0, 1'b1, 1'b1);
        pins(1'b0, 1'b1, 1'b0);
        wr(SEL_SR2, 8'h2a, 1'b1, 1'b1);
        pins(1'b0, 1'b0, 1'b1);
        hold_n_pin_i <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(SEL_SR1, {1'b0, cf[i], 2'h0}, 1'b1, 1'b1);
            pe(1'b0, 2'h0, ad[2*i], ad[2*i], ex[2*i]);
            pe(1'b0, 2'h0, ad[2*i+1], ad[2*i+1], ex[2*i+1]);
        end
        wr(SEL_SR1, 8'h04, 1'b1, 1'b1);
        pe(1'b0, 2'h0, 21'h1effff, 21'h1f0000, 1'b1);
        wr(SEL_SR2, 8'h6a, 1'b1, 1'b1);
        pe(1'b0, 2'h0, 21'h1f0000, 21'h1fffff, 1'b0);
        pe(1'b0, 2'h0, 21'h000000, 21'h000000, 1'b1);
        wr(SEL_SR3, 8'h04, 1'b1, 1'b1);
        pe(1'b0, 2'h0, 21'h1f0000, 21'h1f0000, 1'b1);
        @(posedge clk_i);
        ul_wr_i <= 1'b1;
        @(posedge clk_i);
        ul_wr_i <= 1'b0;
        pe(1'b0, 2'h0, 21'h000000, 21'h00ffff, 1'b0);
        pe(1'b0, 2'h0, 21'h00ffff, 21'h010000, 1'b1);
        wr(SEL_SR2, 8'h6b, 1'b1, 1'b1);
        wr(SEL_SR2, 8'h00, 1'b1, 1'b0);
        rd(SEL_SR2, 8'h6b);
        tally_and_finish();
    end
endmodule
